// file: rtl/ebus_pkg.sv
// constants, field layouts and carrier types for the external bus phase sequencer
// assumes a single 10 MHz system clock and an axi4-lite register port
package ebus_pkg;

  localparam int NSEL = 4;
  localparam int SELW = 2;
  localparam int AW   = 24;
  localparam int DW   = 16;

  // register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_RDATA  = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CLKCTL = 8'h14;
  localparam logic [7:0] OFF_TIMING = 8'h20;

  // command fields
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_SEL   = 2;
  localparam int CMD_UBS   = 4;

  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;

  // per-select timing word fields
  localparam int TF_AB2    = 0;
  localparam int TF_CMD    = 1;
  localparam int TF_DSET   = 3;
  localparam int TF_ACC    = 4;
  localparam int TF_HOLD   = 9;
  localparam int TF_RDYEN  = 11;
  localparam int TF_RDYPOL = 12;
  localparam int TF_RDYASY = 13;
  localparam int TF_WINX   = 14;
  localparam int TF_MUX    = 16;

  localparam logic [31:0] TIMING_RST = 32'h0000_0000;
  localparam logic        CLKEN_RST  = 1'b0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // external pin outputs
  typedef struct packed {
    logic [AW-1:0]   addr;
    logic [NSEL-1:0] cs_n;
    logic            ale;
    logic            rd_n;
    logic            wr_n;
    logic            upper_byte_select_n;
    logic [DW-1:0]   dout;
    logic            doe;
  } pins_out_t;

  typedef struct packed {
    logic [DW-1:0] din;
    logic          ready;
  } pins_in_t;

  typedef enum {
    PH_IDLE, PH_LOAD, PH_AB, PH_C, PH_D, PH_E, PH_F
  } phase_t;

endpackage

// file: rtl/timing_mem.sv
// per-select timing settings store, one write port with byte enables
// two read ports, read data registered one cycle after the address
`timescale 1ns/1ps
module timing_mem #(
  parameter int DEPTH = 4,
  parameter int AWID  = 2
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             we,
  input  wire logic [AWID-1:0]  waddr,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic [AWID-1:0]  raddr_a,
  output logic      [31:0]      rdata_a,
  input  wire logic [AWID-1:0]  raddr_b,
  output logic      [31:0]      rdata_b
);
  import ebus_pkg::*;

  logic [31:0] mem [DEPTH];

  genvar e;
  generate
    for (e = 0; e < DEPTH; e++)
    begin : g_entry
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          mem[e] <= TIMING_RST;
        else if (we && waddr == AWID'(e))
        begin
          for (int b = 0; b < 4; b++)
            if (wstrb[b])
              mem[e][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_a <= TIMING_RST;
      rdata_b <= TIMING_RST;
    end
    else
    begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end

endmodule

// file: rtl/ebus_seq.sv
// external bus cycle phase sequencer with axi4-lite register port
// assumes pin inputs are asynchronous; aclk is also the bus reference clock
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ebus_seq (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire ebus_pkg::pins_in_t   pin_in,
  output ebus_pkg::pins_out_t       pin_out,
  output logic                      external_clock_output,
  output logic                      external_clock_output_en
);
  import ebus_pkg::*;

  typedef struct packed {
    logic            aw_got;
    logic [7:0]      awaddr;
    logic            w_got;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            r_pend;
    logic [7:0]      araddr;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wbuf;
    logic [DW-1:0]   rbuf;
    logic            is_write;
    logic            ubs;
    logic [SELW-1:0] sel;
    logic [SELW-1:0] last_sel;
    logic            last_valid;
    logic            done;
    logic            clk_en;
    phase_t          phase;
    logic [4:0]      cnt;
    logic [31:0]     cfg;
    logic [DW-1:0]   din_s1;
    logic [DW-1:0]   din_s2;
    logic            rdy_s1;
    logic            rdy_s2;
    logic            rdy_s3;
    pins_out_t       pins;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic             mem_we;
  logic [SELW-1:0]  mem_waddr;
  logic [31:0]      mem_rdata_a;
  logic [31:0]      mem_rdata_b;

  timing_mem #(
    .DEPTH (NSEL),
    .AWID  (SELW)
  ) u_timing (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (cur_reg.wdata),
    .wstrb   (cur_reg.wstrb),
    // next-cycle addresses so the registered word is ready one clock later
    .raddr_a (cur_next.araddr[2 +: SELW]),
    .rdata_a (mem_rdata_a),
    .raddr_b (cur_next.sel),
    .rdata_b (mem_rdata_b)
  );

  function automatic logic is_timing(input logic [7:0] a);
    return a >= OFF_TIMING && a < OFF_TIMING + 8'(4 * NSEL);
  endfunction

  // phase lengths from the latched settings
  logic [2:0] len_ab;
  logic [1:0] len_c;
  logic       len_d;
  logic [5:0] len_e;
  logic [1:0] len_f;
  logic       rdy_raw;
  logic       rdy_act;

  always_comb
  begin
    len_ab = cur_reg.cfg[TF_AB2] ? 3'h2 : 3'h1;
    if (!cur_reg.last_valid || cur_reg.last_sel != cur_reg.sel)
      len_ab = len_ab + {1'b0, cur_reg.cfg[TF_WINX +: 2]};
    len_c   = cur_reg.cfg[TF_CMD +: 2];
    len_d   = cur_reg.cfg[TF_DSET];
    len_e   = {1'b0, cur_reg.cfg[TF_ACC +: 5]} + 6'h1;
    len_f   = cur_reg.cfg[TF_HOLD +: 2];
    rdy_raw = cur_reg.cfg[TF_RDYASY] ? cur_reg.rdy_s3 : cur_reg.rdy_s2;
    rdy_act = (rdy_raw == cur_reg.cfg[TF_RDYPOL]);
  end

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;

  assign s_axi_awready = !cur_reg.aw_got && !cur_reg.bvalid;
  assign s_axi_wready  = !cur_reg.w_got && !cur_reg.bvalid;
  assign s_axi_arready = !cur_reg.r_pend && !cur_reg.rvalid;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign wr_go         = cur_reg.aw_got && cur_reg.w_got;
  assign mem_we        = wr_go && is_timing(cur_reg.awaddr);
  assign mem_waddr     = cur_reg.awaddr[2 +: SELW];

  always_comb
  begin
    cur_next = cur_reg;

    // pin input synchronisers
    cur_next.din_s1 = pin_in.din;
    cur_next.din_s2 = cur_reg.din_s1;
    cur_next.rdy_s1 = pin_in.ready;
    cur_next.rdy_s2 = cur_reg.rdy_s1;
    cur_next.rdy_s3 = cur_reg.rdy_s2;

    // write channel
    if (aw_hs)
    begin
      cur_next.aw_got = 1'b1;
      cur_next.awaddr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      cur_next.w_got = 1'b1;
      cur_next.wdata = s_axi_wdata;
      cur_next.wstrb = s_axi_wstrb;
    end
    if (cur_reg.bvalid && s_axi_bready)
      cur_next.bvalid = 1'b0;
    if (wr_go)
    begin
      cur_next.aw_got = 1'b0;
      cur_next.w_got  = 1'b0;
      cur_next.bvalid = 1'b1;
      cur_next.bresp  = RESP_OKAY;
      case (cur_reg.awaddr)
        OFF_CMD:
        begin
          if (cur_reg.wstrb[0] && cur_reg.wdata[CMD_START] && cur_reg.phase == PH_IDLE)
          begin
            cur_next.is_write = cur_reg.wdata[CMD_WRITE];
            cur_next.sel      = cur_reg.wdata[CMD_SEL +: SELW];
            cur_next.ubs      = cur_reg.wdata[CMD_UBS];
            cur_next.done     = 1'b0;
            cur_next.phase    = PH_LOAD;
          end
        end
        OFF_ADDR:
          cur_next.addr = cur_reg.wdata[AW-1:0];
        OFF_WDATA:
          cur_next.wbuf = cur_reg.wdata[DW-1:0];
        OFF_STATUS:
          if (cur_reg.wdata[ST_DONE])
            cur_next.done = 1'b0;
        OFF_CLKCTL:
          cur_next.clk_en = cur_reg.wdata[0];
        OFF_RDATA:
          cur_next.bresp = RESP_OKAY;
        default:
          if (!is_timing(cur_reg.awaddr))
            cur_next.bresp = RESP_SLVERR;
      endcase
    end

    // read channel, one cycle for the settings store
    if (ar_hs)
    begin
      cur_next.r_pend = 1'b1;
      cur_next.araddr = s_axi_araddr;
    end
    if (cur_reg.r_pend)
    begin
      cur_next.r_pend = 1'b0;
      cur_next.rvalid = 1'b1;
      cur_next.rresp  = RESP_OKAY;
      cur_next.rdata  = 32'h0000_0000;
      case (cur_reg.araddr)
        OFF_ADDR:   cur_next.rdata[AW-1:0] = cur_reg.addr;
        OFF_WDATA:  cur_next.rdata[DW-1:0] = cur_reg.wbuf;
        OFF_RDATA:  cur_next.rdata[DW-1:0] = cur_reg.rbuf;
        OFF_CMD:    cur_next.rdata = 32'h0000_0000;
        OFF_STATUS:
        begin
          cur_next.rdata[ST_BUSY] = cur_reg.phase != PH_IDLE;
          cur_next.rdata[ST_DONE] = cur_reg.done;
        end
        OFF_CLKCTL: cur_next.rdata[0] = cur_reg.clk_en;
        default:
          if (is_timing(cur_reg.araddr))
            cur_next.rdata = mem_rdata_a;
          else
            cur_next.rresp = RESP_SLVERR;
      endcase
    end
    if (cur_reg.rvalid && s_axi_rready)
      cur_next.rvalid = 1'b0;

    // phase sequencer
    case (cur_reg.phase)
      PH_IDLE:
        cur_next.cnt = 5'h0;
      PH_LOAD:
      begin
        cur_next.cfg   = mem_rdata_b;
        cur_next.phase = PH_AB;
        cur_next.cnt   = 5'h0;
      end
      PH_AB:
      begin
        if (cur_reg.cnt == 5'(len_ab - 3'h1))
        begin
          cur_next.cnt        = 5'h0;
          cur_next.last_sel   = cur_reg.sel;
          cur_next.last_valid = 1'b1;
          if (len_c != 2'h0)
            cur_next.phase = PH_C;
          else if (len_d)
            cur_next.phase = PH_D;
          else
            cur_next.phase = PH_E;
        end
        else
          cur_next.cnt = cur_reg.cnt + 5'h1;
      end
      PH_C:
      begin
        if (cur_reg.cnt == 5'(len_c - 2'h1))
        begin
          cur_next.cnt   = 5'h0;
          cur_next.phase = len_d ? PH_D : PH_E;
        end
        else
          cur_next.cnt = cur_reg.cnt + 5'h1;
      end
      PH_D:
      begin
        cur_next.cnt   = 5'h0;
        cur_next.phase = PH_E;
      end
      PH_E:
      begin
        if (cur_reg.cnt != 5'(len_e - 6'h1))
          cur_next.cnt = cur_reg.cnt + 5'h1;
        else if (!cur_reg.cfg[TF_RDYEN] || rdy_act)
        begin
          cur_next.cnt = 5'h0;
          if (!cur_reg.is_write)
            cur_next.rbuf = cur_reg.din_s2;
          if (len_f != 2'h0)
            cur_next.phase = PH_F;
          else
          begin
            cur_next.phase = PH_IDLE;
            cur_next.done  = 1'b1;
          end
        end
      end
      PH_F:
      begin
        if (cur_reg.cnt == 5'({3'h0, len_f} - 5'h1))
        begin
          cur_next.cnt   = 5'h0;
          cur_next.phase = PH_IDLE;
          cur_next.done  = 1'b1;
        end
        else
          cur_next.cnt = cur_reg.cnt + 5'h1;
      end
      default:
        cur_next.phase = PH_IDLE;
    endcase

    // pins follow the next phase so they change on the same edge as the phase
    cur_next.pins.ale                 = cur_next.phase == PH_AB;
    cur_next.pins.rd_n                = !(cur_next.phase == PH_E && !cur_reg.is_write);
    cur_next.pins.wr_n                = !(cur_next.phase == PH_E && cur_reg.is_write);
    cur_next.pins.cs_n                = {NSEL{1'b1}};
    cur_next.pins.upper_byte_select_n = 1'b1;
    cur_next.pins.doe                 = 1'b0;
    cur_next.pins.dout                = cur_reg.pins.dout;
    if (cur_next.phase inside {PH_AB, PH_C, PH_D, PH_E, PH_F})
    begin
      cur_next.pins.addr                = cur_reg.addr;
      cur_next.pins.cs_n[cur_reg.sel]   = 1'b0;
      cur_next.pins.upper_byte_select_n = !cur_reg.ubs;
    end
    if (cur_next.phase == PH_AB && cur_next.cfg[TF_MUX])
    begin
      cur_next.pins.doe  = 1'b1;
      cur_next.pins.dout = cur_reg.addr[DW-1:0];
    end
    else if (cur_reg.is_write && (cur_next.phase inside {PH_E, PH_F}
             || (cur_next.phase == PH_D && !cur_next.cfg[TF_MUX])))
    begin
      cur_next.pins.doe  = 1'b1;
      cur_next.pins.dout = cur_reg.wbuf;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cur_reg                          <= '0;
      cur_reg.phase                    <= PH_IDLE;
      cur_reg.cfg                      <= TIMING_RST;
      cur_reg.clk_en                   <= CLKEN_RST;
      cur_reg.pins.cs_n                <= {NSEL{1'b1}};
      cur_reg.pins.rd_n                <= 1'b1;
      cur_reg.pins.wr_n                <= 1'b1;
      cur_reg.pins.upper_byte_select_n <= 1'b1;
    end
    else
      cur_reg <= cur_next;
  end

  assign s_axi_bvalid             = cur_reg.bvalid;
  assign s_axi_bresp              = cur_reg.bresp;
  assign s_axi_rvalid             = cur_reg.rvalid;
  assign s_axi_rdata              = cur_reg.rdata;
  assign s_axi_rresp              = cur_reg.rresp;
  assign pin_out                  = cur_reg.pins;
  assign external_clock_output    = aclk & cur_reg.clk_en;
  assign external_clock_output_en = cur_reg.clk_en;

endmodule

// file: tb/ebus_seq_chk.sv
// assertions on the sequencer's register port and external bus pins
// bound to ebus_seq, sees only its ports
`timescale 1ns/1ps
module ebus_seq_chk (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire ebus_pkg::pins_out_t pin_out
);
  import ebus_pkg::*;
  wire logic cmd = !pin_out.rd_n || !pin_out.wr_n;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_cmd_excl: assert property (pin_out.rd_n || pin_out.wr_n)
    else $error("read and write strobes low together");
  a_cmd_after_ab: assert property ($rose(cmd) |-> !pin_out.ale && (pin_out.cs_n != '1))
    else $error("strobe fell outside a selected cycle");
  a_ab_len: assert property ($rose(pin_out.ale) |-> ##[1:5] !pin_out.ale)
    else $error("address setup longer than five clocks");
  a_ab_to_cmd: assert property ($fell(pin_out.ale) |-> ##[0:4] cmd)
    else $error("command delay and data setup too long");
  a_wr_stable: assert property (!pin_out.wr_n && $past(!pin_out.wr_n)
    |-> $stable(pin_out.dout) && $stable(pin_out.addr) && pin_out.doe)
    else $error("write data or address moved during access");
  a_rd_float: assert property (!pin_out.rd_n |-> !pin_out.doe)
    else $error("data bus driven during read");
  a_hold_len: assert property ($fell(cmd) |-> ##[0:3] (&pin_out.cs_n))
    else $error("hold phase longer than three clocks");
  a_one_sel: assert property (pin_out.ale |-> $countones(~pin_out.cs_n) == 1)
    else $error("not exactly one select active");
  a_b_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read response late");
  c_read: cover property ($rose(pin_out.rd_n));
  c_write: cover property ($rose(pin_out.wr_n));
  c_long: cover property (cmd [*8]);
  c_bresp: cover property (s_axi_bvalid);
endmodule

bind ebus_seq ebus_seq_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .pin_out(pin_out));

// file: tb/ext_mem.sv
// behavioural external memory on the demultiplexed bus with a ready handshake
// assumes the sequencer's clock; ready turns active a set number of clocks into the strobe
`timescale 1ns/1ps
module ext_mem (
  input  wire logic                aclk,
  input  wire ebus_pkg::pins_out_t pin_out,
  output ebus_pkg::pins_in_t       pin_in,
  input  wire logic                rdy_pol,
  input  wire integer              rdy_dly
);
  import ebus_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] wd_q;
  logic [23:0] wa_q;
  logic        rd_seen;
  logic        wr_q;
  int          cnt;
  wire logic   cmd = !pin_out.rd_n || !pin_out.wr_n;
  wire logic   sel_on = !(&pin_out.cs_n);
  initial pin_in = '0;
  always @(posedge aclk)
  begin
    cnt <= cmd ? cnt + 1 : 0;
    rd_seen <= sel_on && (rd_seen || !pin_out.rd_n);
    wr_q <= !pin_out.wr_n;
    if (!pin_out.wr_n)
    begin
      wa_q <= pin_out.addr;
      wd_q <= pin_out.dout;
    end
    if (wr_q && pin_out.wr_n)
      mem[int'(wa_q)] = wd_q;
    // released bus toggles so a stale value is never seen
    if (sel_on && pin_out.wr_n && !(rd_seen && pin_out.rd_n))
      pin_in.din <= mem.exists(int'(pin_out.addr)) ? mem[int'(pin_out.addr)] : pin_out.addr[15:0] ^ 16'hA5A5;
    else
      pin_in.din <= ~pin_in.din;
    pin_in.ready <= (cmd && cnt >= rdy_dly) ? rdy_pol : !rdy_pol;
  end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the external bus phase sequencer
// assumes ebus_seq, its checker and the ext_mem partner model
`timescale 1ns/1ps
module tb_top;
  import ebus_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rdy_pol;
  logic        awready, wready, bvalid, arready, rvalid, ext_clk, ext_en, ubs_seen;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  pins_in_t    pin_in;
  pins_out_t   pin_out;
  int          rdy_dly, n_mismatch, n_tests, n_ab, n_cd, n_e, n_f, n_ord, prev_sel, k;
  logic [15:0] mdl [int];
  ebus_seq DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .external_clock_output(ext_clk), .external_clock_output_en(ext_en));
  ext_mem u_mem (.aclk(aclk), .pin_out(pin_out), .pin_in(pin_in), .rdy_pol(rdy_pol), .rdy_dly(rdy_dly));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // phase lengths seen on the pins
  always @(posedge aclk)
    if (!(&pin_out.cs_n))
    begin
      if (pin_out.ale)
        n_ord += (n_cd + n_e + n_f > 0);
      if (pin_out.ale)
        ubs_seen = pin_out.upper_byte_select_n;
      if (pin_out.ale)
        n_ab++;
      else if (!pin_out.rd_n || !pin_out.wr_n)
        n_e += 1 + (n_f > 0) * 100;
      else if (n_e == 0)
        n_cd++;
      else
        n_f++;
    end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task hang(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected answer seen none", nm);
    complete_run;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (i == 50)
      hang("bvalid");
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (i == 50)
      hang("rvalid");
    @(posedge aclk);
  endtask
  task automatic bus_cycle(input int k);
    int sel, ab2, c, d, acc, hold, winx, rdy, wr, i, ub;
    logic [23:0] a;
    logic [15:0] dat;
    logic [31:0] tw;
    sel = (k == 1) ? (prev_sel + 1) % 4 : $urandom_range(0, 3);
    ab2 = $urandom_range(0, 1);
    c = $urandom_range(0, 3);
    d = $urandom_range(0, 1);
    hold = $urandom_range(0, 3);
    winx = $urandom_range(0, 3);
    wr = $urandom_range(0, 1);
    ub = $urandom_range(0, 1);
    rdy = (k >= 12);
    acc = rdy ? $urandom_range(1, 4) : $urandom_range(wr ? 1 : 4, 32);
    if (k == 0)
      {ab2, c, d, acc, hold, winx, wr} = {32'd0, 32'd0, 32'd0, 32'd1, 32'd0, 32'd0, 32'd1};
    if (k == 1)
      {ab2, c, d, acc, hold, winx, wr} = {32'd1, 32'd3, 32'd1, 32'd32, 32'd3, 32'd3, 32'd0};
    a = 24'($urandom_range(0, 7) * 2);
    dat = 16'($urandom);
    rdy_dly = $urandom_range(6, 9);
    rdy_pol = 1'($urandom_range(0, 1));
    tw = {15'h0, 1'($urandom_range(0, 1)), 2'(winx), 1'($urandom_range(0, 1)), rdy_pol, 1'(rdy), 2'(hold),
      5'(acc - 1), 1'(d), 2'(c),
      1'(ab2)};
    axi_wr(OFF_TIMING + 8'(4 * sel), tw);
    axi_wr(OFF_ADDR, {8'h00, a});
    if (wr)
      axi_wr(OFF_WDATA, {16'h0, dat});
    {n_ab, n_cd, n_e, n_f, n_ord} = '0;
    axi_wr(OFF_CMD, (32'(ub) << CMD_UBS) | (32'(sel) << CMD_SEL) | (32'(wr) << CMD_WRITE) | 32'h1);
    chk("start resp", resp, RESP_OKAY);
    for (i = 0; i < 60; i++)
    begin
      axi_rd(OFF_STATUS);
      if (rd_val[ST_DONE] === 1'b1)
        break;
    end
    if (i == 60)
      hang("done");
    chk("busy clear", rd_val[ST_BUSY], 1'b0);
    chk("byte select", ubs_seen, 32'(ub == 0));
    chk("setup clocks", n_ab, ab2 + 1 + (sel != prev_sel ? winx : 0));
    chk("delay clocks", n_cd, c + d);
    if (rdy)
      chk("ready stretch", n_e >= rdy_dly + 1 && n_e <= rdy_dly + 6, 1);
    else
      chk("access clocks", n_e, acc);
    chk("hold clocks", n_f, hold);
    chk("phase order", n_ord, 0);
    if (wr)
      mdl[int'(a)] = dat;
    if (wr)
      chk("written word", u_mem.mem[int'(a)], dat);
    else
      axi_rd(OFF_RDATA);
    if (!wr)
      chk("read word", rd_val[15:0], mdl.exists(int'(a)) ? mdl[int'(a)] : a[15:0] ^ 16'hA5A5);
    axi_rd(OFF_ADDR);
    chk("addr readback", rd_val, {8'h00, a});
    axi_wr(OFF_STATUS, 32'h1 << ST_DONE);
    axi_rd(OFF_STATUS);
    chk("done cleared", rd_val[ST_DONE], 1'b0);
    prev_sel = sel;
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {wstrb, rdy_pol, rdy_dly, n_mismatch, n_tests, prev_sel} = {4'hF, 1'b1, 32'd0, 32'd0, 32'd0, -32'sd1};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    void'($urandom(32'h5F00));
    axi_rd(OFF_TIMING);
    chk("timing reset", rd_val, TIMING_RST);
    axi_rd(OFF_CLKCTL);
    chk("clkctl reset", rd_val, {31'h0, CLKEN_RST});
    chk("driver reset", ext_en, 1'b0);
    axi_rd(8'h18);
    chk("unmapped read", resp, RESP_SLVERR);
    axi_wr(OFF_CLKCTL, 32'h1);
    #1;
    chk("driver on", ext_en, 1'b1);
    chk("clock high", ext_clk, 1'b1);
    @(negedge aclk);
    #1;
    chk("clock low", ext_clk, 1'b0);
    @(posedge aclk);
    for (k = 0; k < 20; k++)
      bus_cycle(k);
    complete_run;
  end
endmodule
